/* File: core/mhb_addr_latch.sv */
// Address, endianness and direct select latch of the multiplexed host bus.
`timescale 1ns/1ps
`default_nettype none

module mhb_addr_latch
	import mhb_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Pin data and qualified, polarity-corrected latch strobes.
	input wire logic [mhb_pkg::PIN_W-1:0] ad_in,
	input wire logic lo_act,
	input wire logic hi_act,
	// Bus mode, taken from straps.
	input wire logic wide_mode,
	input wire logic dual_mode,
	// Latched results.
	output logic [mhb_pkg::ADDR_W-1:0] addr_q,
	output logic endian_q,
	output logic direct_q
);

	// Previous strobe levels for trailing-edge detection.
	logic lo_prev_q, lo_prev_d, hi_prev_q, hi_prev_d;
	logic [ADDR_W-1:0] addr_d;
	logic endian_d, direct_d;
	logic lo_fall, hi_fall;

	// Next values: a skipped strobe simply leaves its portion untouched.
	always_comb begin
		lo_prev_d = lo_act;
		hi_prev_d = hi_act;
		addr_d = addr_q;
		endian_d = endian_q;
		direct_d = direct_q;
		lo_fall = lo_prev_q && !lo_act;
		hi_fall = hi_prev_q && !hi_act;
		if (!dual_mode) begin
			// Single phase: the low strobe carries everything. [R19]
			if (lo_fall && wide_mode) begin
				addr_d = {ad_in[8:0], 1'b0};
				endian_d = ad_in[9]; // [R23]
				direct_d = ad_in[10]; // [R24]
			end else if (lo_fall) begin
				addr_d = ad_in[9:0];
				endian_d = ad_in[10]; // [R23]
				direct_d = ad_in[11]; // [R24]
			end
		end else begin
			// Dual phase: either strobe, in any order, or none. [R18]
			if (lo_fall && wide_mode) begin
				addr_d[8:0] = {ad_in[7:0], 1'b0};
			end else if (lo_fall) begin
				addr_d[7:0] = ad_in[7:0];
			end
			if (hi_fall && wide_mode) begin
				addr_d[9] = ad_in[0];
				endian_d = ad_in[1]; // [R23]
				direct_d = ad_in[2]; // [R24]
			end else if (hi_fall) begin
				addr_d[9:8] = ad_in[1:0];
				endian_d = ad_in[2]; // [R23]
				direct_d = ad_in[3]; // [R24]
			end
		end
	end

	// Register stage; the address is kept until reset or a new latch.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lo_prev_q <= 1'b0;
			hi_prev_q <= 1'b0;
			addr_q <= ADDR_RST;
			endian_q <= ENDIAN_RST;
			direct_q <= DIRECT_RST;
		end else if (ce) begin
			lo_prev_q <= lo_prev_d;
			hi_prev_q <= hi_prev_d;
			addr_q <= addr_d;
			endian_q <= endian_d;
			direct_q <= direct_d;
		end
	end

endmodule

`default_nettype wire

/* File: core/mhb_lane_sel.sv */
// Byte lane selector from the little-endian internal word to host pins.
`timescale 1ns/1ps
`default_nettype none

module mhb_lane_sel
	import mhb_pkg::*;
(
	// Internal word and lane selection.
	input wire logic [mhb_pkg::DATA_W-1:0] dword,
	input wire logic [1:0] lane,
	input wire logic endian,
	input wire logic wide_mode,
	// Host-ordered result, low byte only in 8-bit mode.
	output logic [mhb_pkg::PIN_W-1:0] host_data
);

	logic [7:0] b0, b1, b2, b3;
	logic [7:0] sel_byte;

	// Split the word into its four bytes.
	assign b0 = dword[7:0];
	assign b1 = dword[15:8];
	assign b2 = dword[23:16];
	assign b3 = dword[31:24];

	// Reordering combines the endianness bit with the low address bits.
	always_comb begin
		sel_byte = b0;
		host_data = {b1, b0};
		if (wide_mode) begin
			// Big endian mirrors the word and swaps its bytes. [R25]
			case ({endian, lane[1]})
				2'b00: host_data = {b1, b0};
				2'b01: host_data = {b3, b2};
				2'b10: host_data = {b2, b3};
				2'b11: host_data = {b0, b1};
				default: host_data = {b1, b0};
			endcase
		end else begin
			// Big endian maps the lowest host byte to the top lane. [R25]
			case (endian ? ~lane : lane)
				2'h0: sel_byte = b0;
				2'h1: sel_byte = b1;
				2'h2: sel_byte = b2;
				2'h3: sel_byte = b3;
				default: sel_byte = b0;
			endcase
			host_data = {8'h00, sel_byte};
		end
	end

endmodule

`default_nettype wire

/* File: core/mhb_pkg.sv */
// Shared constants for the multiplexed host bus read path.
package mhb_pkg;

	// Width of the multiplexed address / data pins.
	localparam int PIN_W = 16;
	// Width of the latched byte address.
	localparam int ADDR_W = 10;
	// Width of the internal register data path.
	localparam int DATA_W = 32;
	// Width of the hardware event vector whose updates may be deferred.
	localparam int EVT_W = 8;

	// Last part index of a DWORD read in 8-bit mode (four parts).
	localparam logic [1:0] LAST_PART_8 = 2'h3;
	// Last part index of a DWORD read in 16-bit mode (two parts).
	localparam logic [1:0] LAST_PART_16 = 2'h1;

	// Byte address of the receive data FIFO port.
	localparam logic [ADDR_W-1:0] RXD_ADDR = 10'h000;
	// Byte address of the receive status FIFO, popping access.
	localparam logic [ADDR_W-1:0] RXS_ADDR = 10'h040;
	// Byte address of the receive status FIFO, peek access.
	localparam logic [ADDR_W-1:0] RXS_PEEK_ADDR = 10'h044;
	// Byte address of the transmit status FIFO, popping access.
	localparam logic [ADDR_W-1:0] TXS_ADDR = 10'h048;
	// Byte address of the transmit status FIFO, peek access.
	localparam logic [ADDR_W-1:0] TXS_PEEK_ADDR = 10'h04c;
	// Byte address of the register that may be polled one part at a time.
	localparam logic [ADDR_W-1:0] POLL_ADDR = 10'h064;

	// Reset values of the latched address, endianness and direct select.
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	localparam logic ENDIAN_RST = 1'b0;
	localparam logic DIRECT_RST = 1'b0;
	// Reset value of the read part counter.
	localparam logic [1:0] COUNT_RST = 2'h0;
	// Reset value of the held register word.
	localparam logic [DATA_W-1:0] HOLD_RST = 32'h0000_0000;

	// States of the host read cycle tracker.
	typedef enum logic [1:0] {
		MHB_RD_IDLE,
		MHB_RD_ACTIVE,
		MHB_RD_IGNORE
	} mhb_rd_state_t;

endpackage

/* File: core/mhb_read_path.sv */
// Read path and access control of the multiplexed 8/16-bit host bus.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: Reads ignored outside full power state.
// R2: Power returning mid-read ignores remaining cycle.
// R3: Host completes DWORD with two or four parts.
// R4: Host never rereads a part; undefined.
// R5: Separate read counter; last part commits internally.
// R6: Leaving full power clears read counter.
// R7: Live bits frozen from read start.
// R8: Multi-part registers locked first to last.
// R9: Leaving full power releases all locks.
// R10: Pops and side effects once, at end.
// R11: Events during hold or lock are deferred.
// R12: Poll register accepts single repeated reads.
// R13: Latched endianness select picks byte order.
// R14: Bytes reordered by endianness and address.
// R15: Status FIFO pops normally, peek does not.
// R16: Direct select reads receive data FIFO.
// R17: Host avoids receive FIFO bursts; relatch optional.
// R18: Dual phase strobes any order or skipped.
// R19: Single phase low strobe may be skipped.
// R20: Host stays in one DWORD until done.
// R21: Straps set polarities and strobe style.
// R22: Strap sets latch gating by chip select.
// R23: Endianness bit one above top address.
// R24: Direct select two above top address.
// R25: Big endian mirrors lane selection.
module mhb_read_path
	import mhb_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Multiplexed address / data pins, split into three signals.
	input wire logic [mhb_pkg::PIN_W-1:0] ad_in,
	output logic [mhb_pkg::PIN_W-1:0] ad_out,
	output logic [mhb_pkg::PIN_W-1:0] ad_oe,
	// Host control pins.
	input wire logic low_address_latch,
	input wire logic high_address_latch,
	input wire logic select_in,
	input wire logic read_dir_in,
	input wire logic access_enable_input,
	// Configuration straps, caught after reset release.
	input wire logic latch_polarity_config,
	input wire logic select_polarity_config,
	input wire logic read_dir_polarity_config,
	input wire logic store_enable_polarity_config,
	input wire logic strobe_style_config,
	input wire logic latch_gating_config,
	input wire logic wide_mode_config,
	input wire logic dual_phase_config,
	// Power management.
	input wire logic full_power_state,
	// Register file side.
	input wire logic [mhb_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [mhb_pkg::EVT_W-1:0] hw_event,
	output logic [mhb_pkg::ADDR_W-1:0] rd_addr,
	output logic read_hold,
	output logic read_lock,
	output logic read_commit,
	output logic rxd_pop,
	output logic rxs_pop,
	output logic txs_pop,
	output logic [mhb_pkg::EVT_W-1:0] event_apply,
	output logic [1:0] rd_count,
	// Shared with the write path.
	output logic [mhb_pkg::ADDR_W-1:0] latched_addr,
	output logic latched_endian,
	output logic latched_direct
);

	import mhb_pkg::*;

	// Captured straps; they are levels caught once, after reset.
	logic strap_done_q, strap_done_d;
	logic [7:0] strap_q, strap_d;
	logic lat_pol, sel_pol, dir_pol, en_pol, style, gate, wide, dual;

	// Decoded, polarity-corrected control levels.
	logic sel_act, dir_act, en_act, rd_cyc, lo_act, hi_act;

	// Read tracker state.
	mhb_rd_state_t st_q, st_d;
	logic [1:0] cnt_q, cnt_d;
	logic lock_q, lock_d;
	logic [DATA_W-1:0] hold_q, hold_d;
	logic [PIN_W-1:0] out_q, out_d;
	logic commit_q, commit_d;
	logic rxd_q, rxd_d, rxs_q, rxs_d, txs_q, txs_d;
	logic [EVT_W-1:0] pend_q, pend_d, apply_q, apply_d;

	// Combinational helpers.
	logic [ADDR_W-1:0] dw_addr;
	logic [1:0] last_part;
	logic poll_hit, last_hit, held;
	logic [DATA_W-1:0] src_word;
	logic [PIN_W-1:0] lane_data;

	// Straps are sampled while not yet done, so reset loads only constants.
	always_comb begin
		strap_done_d = 1'b1;
		strap_d = strap_q;
		if (!strap_done_q) begin
			strap_d = {latch_polarity_config, select_polarity_config,
				read_dir_polarity_config, store_enable_polarity_config,
				strobe_style_config, latch_gating_config,
				wide_mode_config, dual_phase_config};
		end
	end

	// Strap register.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_done_q <= 1'b0;
			strap_q <= 8'h00;
		end else if (ce) begin
			strap_done_q <= strap_done_d;
			strap_q <= strap_d;
		end
	end

	// A set polarity bit means the line is active high.
	assign {lat_pol, sel_pol, dir_pol, en_pol, style, gate, wide, dual} =
		strap_q;

	// Control decoding; until the straps are caught no cycle is seen.
	always_comb begin
		sel_act = strap_done_q && (select_in ~^ sel_pol); // [R21]
		dir_act = read_dir_in ~^ dir_pol; // [R21]
		en_act = access_enable_input ~^ en_pol; // [R21]
		// Separate strobes, or an enable qualified by direction. [R21]
		rd_cyc = sel_act && (style ? (en_act && dir_act) : dir_act);
		// Latch strobes may need chip select as well. [R22]
		lo_act = strap_done_q && (low_address_latch ~^ lat_pol) &&
			(!gate || sel_act);
		hi_act = strap_done_q && (high_address_latch ~^ lat_pol) &&
			(!gate || sel_act);
	end

	// Address latch shared with the write path.
	mhb_addr_latch u_latch (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.ad_in(ad_in),
		.lo_act(lo_act),
		.hi_act(hi_act),
		.wide_mode(wide),
		.dual_mode(dual),
		.addr_q(latched_addr),
		.endian_q(latched_endian),
		.direct_q(latched_direct)
	);

	// Address decode for the register file side.
	always_comb begin
		dw_addr = {latched_addr[ADDR_W-1:2], 2'b00};
		// Direct select ignores all but the lane bits. [R16]
		rd_addr = latched_direct ? RXD_ADDR : dw_addr;
		last_part = wide ? LAST_PART_16 : LAST_PART_8;
		// The poll register never needs its other parts. [R12]
		poll_hit = !latched_direct && (dw_addr == POLL_ADDR);
		last_hit = poll_hit || (cnt_q == last_part); // [R5]
		held = (st_q == MHB_RD_ACTIVE) || lock_q;
		// A locked word is replayed instead of the live value. [R8]
		src_word = lock_q ? hold_q : reg_rdata;
	end

	// Lane selection follows the latched endianness and address. [R13]
	mhb_lane_sel u_lane (
		.dword(src_word),
		.lane(latched_addr[1:0]),
		.endian(latched_endian),
		.wide_mode(wide),
		.host_data(lane_data)
	); // [R14]

	// Read cycle tracker. The counter only counts parts; a host that
	// rereads one part still completes the word early, by design.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		lock_d = lock_q;
		hold_d = hold_q;
		out_d = out_q;
		commit_d = 1'b0;
		rxd_d = 1'b0;
		rxs_d = 1'b0;
		txs_d = 1'b0;
		case (st_q)
			MHB_RD_IDLE: begin
				if (rd_cyc && !full_power_state) begin
					// A cycle begun in low power is ignored whole. [R1]
					st_d = MHB_RD_IGNORE;
				end else if (rd_cyc) begin
					// Freeze the word at the start of the cycle. [R7]
					st_d = MHB_RD_ACTIVE;
					hold_d = src_word;
					out_d = lane_data;
					if (!poll_hit && cnt_q == 2'h0 && !last_hit) begin
						lock_d = 1'b1; // [R8]
					end
				end
			end
			MHB_RD_ACTIVE: begin
				if (!full_power_state) begin
					// Power left mid-cycle; the rest is dropped. [R1]
					st_d = rd_cyc ? MHB_RD_IGNORE : MHB_RD_IDLE;
				end else if (!rd_cyc) begin
					// Trailing edge: count the part. [R5]
					st_d = MHB_RD_IDLE;
					cnt_d = cnt_q + 2'h1;
					if (last_hit) begin
						// One internal read on the last part. [R10]
						cnt_d = COUNT_RST;
						lock_d = 1'b0; // [R8]
						commit_d = 1'b1; // [R5]
						// Status FIFOs pop, peek addresses do not. [R15]
						rxd_d = latched_direct; // [R16]
						rxs_d = !latched_direct && (dw_addr == RXS_ADDR);
						txs_d = !latched_direct && (dw_addr == TXS_ADDR);
					end
				end
			end
			MHB_RD_IGNORE: begin
				// Tail of an ignored cycle, even after power returns. [R2]
				if (!rd_cyc) begin
					st_d = MHB_RD_IDLE;
				end
			end
			default: begin
				st_d = MHB_RD_IDLE;
			end
		endcase
		if (!full_power_state) begin
			cnt_d = COUNT_RST; // [R6]
			lock_d = 1'b0; // [R9]
		end
	end

	// Read tracker registers.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= MHB_RD_IDLE;
			cnt_q <= COUNT_RST;
			lock_q <= 1'b0;
			hold_q <= HOLD_RST;
			out_q <= 16'h0000;
			commit_q <= 1'b0;
			rxd_q <= 1'b0;
			rxs_q <= 1'b0;
			txs_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			lock_q <= lock_d;
			hold_q <= hold_d;
			out_q <= out_d;
			commit_q <= commit_d;
			rxd_q <= rxd_d;
			rxs_q <= rxs_d;
			txs_q <= txs_d;
		end
	end

	// Event deferral: while held or locked, events collect; a new event
	// always wins over the release so nothing is lost. [R11]
	always_comb begin
		pend_d = pend_q | hw_event;
		apply_d = {EVT_W{1'b0}};
		if (!held && !commit_q) begin
			apply_d = pend_q | hw_event;
			pend_d = {EVT_W{1'b0}};
		end
	end

	// Event deferral registers.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pend_q <= {EVT_W{1'b0}};
			apply_q <= {EVT_W{1'b0}};
		end else if (ce) begin
			pend_q <= pend_d;
			apply_q <= apply_d;
		end
	end

	// Pins are driven only during an accepted cycle, low byte in 8-bit.
	assign ad_out = out_q;
	assign ad_oe = (st_q != MHB_RD_ACTIVE) ? 16'h0000 :
		(wide ? 16'hffff : 16'h00ff);

	// Status toward the register file.
	assign read_hold = (st_q == MHB_RD_ACTIVE); // [R7]
	assign read_lock = lock_q; // [R8]
	assign read_commit = commit_q; // [R10]
	assign rxd_pop = rxd_q;
	assign rxs_pop = rxs_q;
	assign txs_pop = txs_q;
	assign event_apply = apply_q;
	assign rd_count = cnt_q;

endmodule

`default_nettype wire

/* File: tb/mhb_host_model.sv */
// Host side model driving the multiplexed bus pins.
`timescale 1ns/1ps
`default_nettype none

module mhb_host_model
	import mhb_pkg::*;
(
	// Clock.
	input wire logic clock,
	// Pins toward the device.
	output logic [mhb_pkg::PIN_W-1:0] ad_in,
	output logic low_address_latch,
	output logic high_address_latch,
	output logic select_in,
	output logic read_dir_in,
	output logic access_enable_input
);
	// Idle bus; single phase never uses the high strobe.
	initial begin
		ad_in = 16'h0000;
		low_address_latch = 1'b0;
		high_address_latch = 1'b0;
		select_in = 1'b0;
		read_dir_in = 1'b0;
		access_enable_input = 1'b0;
	end

	// Address phase; afterwards the bus shows the inverse as released.
	// The hi argument picks the high strobe instead of the low one.
	task automatic latch(input logic [15:0] v, input logic cs, hi);
		@(posedge clock);
		ad_in <= v;
		low_address_latch <= !hi;
		high_address_latch <= hi;
		select_in <= cs;
		@(posedge clock);
		low_address_latch <= 1'b0;
		high_address_latch <= 1'b0;
		@(posedge clock);
		ad_in <= ~v;
		select_in <= 1'b0;
		@(posedge clock);
	endtask

	// One narrow read part, then idle edges before the next.
	task automatic rd();
		@(posedge clock);
		select_in <= 1'b1;
		read_dir_in <= 1'b1;
		access_enable_input <= 1'b1;
		repeat (3) @(posedge clock);
		select_in <= 1'b0;
		read_dir_in <= 1'b0;
		access_enable_input <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
endmodule

`default_nettype wire

/* File: tb/mhb_read_path_sva.sv */
// Assertion checker for the multiplexed host bus read path.
`timescale 1ns/1ps
`default_nettype none

module mhb_read_path_sva
	import mhb_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Mode and power inputs.
	input wire logic wide_mode_config,
	input wire logic full_power_state,
	// Pin side outputs.
	input wire logic [mhb_pkg::PIN_W-1:0] ad_out,
	input wire logic [mhb_pkg::PIN_W-1:0] ad_oe,
	// Register file side outputs.
	input wire logic [mhb_pkg::ADDR_W-1:0] rd_addr,
	input wire logic read_hold,
	input wire logic read_lock,
	input wire logic read_commit,
	input wire logic rxd_pop,
	input wire logic rxs_pop,
	input wire logic txs_pop,
	input wire logic [mhb_pkg::EVT_W-1:0] event_apply,
	input wire logic [1:0] rd_count,
	input wire logic latched_direct
);
	// One clock domain, so clocking and reset are stated once.
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// A driven cycle, and one that lasts two edges.
	sequence s_drive; ad_oe != 16'h0000; endsequence
	sequence s_drive2; s_drive ##1 s_drive; endsequence

	property p_lanes;
		s_drive |-> ad_oe == (wide_mode_config ? 16'hffff : 16'h00ff);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("Output enable pattern is wrong.");
	property p_off; !full_power_state |=> ad_oe == 16'h0000; endproperty
	a_off: assert property (p_off)
		else $error("Pins driven outside full power.");
	property p_count; !full_power_state |=> rd_count == 2'h0; endproperty
	a_count: assert property (p_count)
		else $error("Read count kept outside full power.");
	property p_unlock; !full_power_state |=> !read_lock; endproperty
	a_unlock: assert property (p_unlock)
		else $error("Lock kept outside full power.");
	property p_hold; s_drive |-> read_hold; endproperty
	a_hold: assert property (p_hold)
		else $error("Live bits not held during a read.");
	property p_steady; s_drive2 |-> $stable(ad_out); endproperty
	a_steady: assert property (p_steady)
		else $error("Read data changed inside a cycle.");
	property p_end; read_commit |-> ad_oe == 16'h0000 && !read_lock; endproperty
	a_end: assert property (p_end)
		else $error("Commit not at the end of the last part.");
	property p_pulse; read_commit |=> !read_commit; endproperty
	a_pulse: assert property (p_pulse)
		else $error("Commit longer than one cycle.");
	property p_pops; rxd_pop || rxs_pop || txs_pop |-> read_commit; endproperty
	a_pops: assert property (p_pops)
		else $error("Pop without an internal read.");
	property p_peek;
		read_commit && (rd_addr == RXS_PEEK_ADDR || rd_addr == TXS_PEEK_ADDR)
			|-> !rxs_pop && !txs_pop;
	endproperty
	a_peek: assert property (p_peek)
		else $error("Peek access advanced a status queue.");
	property p_direct; latched_direct |-> rd_addr == RXD_ADDR; endproperty
	a_direct: assert property (p_direct)
		else $error("Direct select not routed to receive data.");
	// The batch registered at a hold's first edge was taken before the
	// hold, so the check looks one cycle after each held cycle.
	property p_defer;
		read_hold || read_lock || read_commit |=> event_apply == 8'h00;
	endproperty
	a_defer: assert property (p_defer)
		else $error("Event applied while held or locked.");
endmodule

bind mhb_read_path mhb_read_path_sva mhb_read_path_sva_i (.clock, .rst,
	.wide_mode_config, .full_power_state, .ad_out, .ad_oe, .rd_addr,
	.read_hold, .read_lock, .read_commit, .rxd_pop, .rxs_pop, .txs_pop,
	.event_apply, .rd_count, .latched_direct);

`default_nettype wire

/* File: tb/tb_mhb_read_path.sv */
// Self-checking testbench for the multiplexed host bus read path.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	miscompares++; $display("[FAIL] %0t value mismatch", $time); end end

module tb_mhb_read_path;
	import mhb_pkg::*;
	// Design pins and bench state.
	logic clock, rst, full_power_state;
	logic ce = 1'b1;
	// Straps that a mid-run reset changes.
	logic wide_cfg = 1'b1, dual_cfg = 1'b0, style_cfg = 1'b0;
	logic [PIN_W-1:0] ad_in, ad_out, ad_oe;
	logic [PIN_W-1:0] oe_was = 16'h0000;
	logic low_address_latch, high_address_latch, select_in;
	logic read_dir_in, access_enable_input;
	logic [DATA_W-1:0] reg_rdata, w;
	logic [EVT_W-1:0] hw_event, event_apply;
	logic [EVT_W-1:0] ev_acc = 8'h00;
	logic [ADDR_W-1:0] rd_addr, latched_addr;
	logic read_hold, read_lock, read_commit, rxd_pop, rxs_pop, txs_pop;
	logic latched_endian, latched_direct;
	logic [1:0] rd_count;
	logic [15:0] expq[$];
	logic [ADDR_W-1:0] st[4] = '{RXS_ADDR, RXS_PEEK_ADDR, TXS_ADDR,
		TXS_PEEK_ADDR};
	int pops[4] = '{1, 0, 1, 0};
	int miscompares = 0, tests_run = 0, c, seed = 32'h5084;
	int n_com = 0, n_rxs = 0, n_txs = 0, n_rxd = 0;

	mhb_read_path mhb_read_path_i (.clock, .rst, .ce, .ad_in, .ad_out,
		.ad_oe, .low_address_latch, .high_address_latch, .select_in,
		.read_dir_in, .access_enable_input, .latch_polarity_config(1'b1),
		.select_polarity_config(1'b1), .read_dir_polarity_config(1'b1),
		.store_enable_polarity_config(1'b1), .strobe_style_config(style_cfg),
		.latch_gating_config(1'b1), .wide_mode_config(wide_cfg),
		.dual_phase_config(dual_cfg), .full_power_state, .reg_rdata, .hw_event,
		.rd_addr, .read_hold, .read_lock, .read_commit, .rxd_pop, .rxs_pop,
		.txs_pop, .event_apply, .rd_count, .latched_addr, .latched_endian,
		.latched_direct);
	mhb_host_model mhb_host_model_i (.clock, .ad_in, .low_address_latch,
		.high_address_latch, .select_in, .read_dir_in, .access_enable_input);

	// Clock of 100 ns period.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Notes the expected host word, then latches and reads one part.
	task automatic part(input logic [9:0] a, input logic e, d,
		input logic [31:0] x);
		logic [15:0] h;
		h = (a[1] ^ e) ? x[31:16] : x[15:0];
		expq.push_back(e ? {h[7:0], h[15:8]} : h);
		mhb_host_model_i.latch({5'h00, d, e, a[9:1]}, 1'b1, 1'b0);
		mhb_host_model_i.rd();
	endtask

	// Whole DWORD in two parts; the live word changes between them.
	task automatic dw(input logic [9:0] a, input logic e, d);
		w = $random(seed);
		reg_rdata <= w;
		part(a, e, d, w);
		reg_rdata <= ~w;
		part(a ^ 10'h002, e, d, w);
	endtask

	// Watcher: a new driven cycle takes the oldest note; pulses are counted.
	always @(negedge clock) begin
		if (ad_oe !== 16'h0000 && oe_was === 16'h0000) begin
			if (expq.size() == 0) `CHK(ad_oe, 16'h0000)
			else `CHK(ad_out, expq.pop_front())
		end
		oe_was = ad_oe;
		ev_acc = ev_acc | event_apply;
		n_com += (read_commit === 1'b1);
		n_rxs += (rxs_pop === 1'b1);
		n_txs += (txs_pop === 1'b1);
		n_rxd += (rxd_pop === 1'b1);
	end

	// A hang counts as a mismatch.
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		conclude();
	end

	// Main sequence of scenarios.
	initial begin
		rst = 1'b1;
		full_power_state = 1'b1;
		reg_rdata = 32'h0000_0000;
		hw_event = 8'h00;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(latched_addr, ADDR_RST)
		dw(10'h010, 1'b0, 1'b0);
		dw(10'h022, 1'b1, 1'b0);
		`CHK(n_com, 2)
		foreach (st[i]) begin
			c = n_rxs + n_txs;
			dw(st[i], 1'b0, 1'b0);
			`CHK(n_rxs + n_txs - c, pops[i])
		end
		c = n_rxd;
		dw(10'h3f4, 1'b1, 1'b1);
		`CHK(n_rxd - c, 1)
		`CHK(latched_direct, 1'b1)
		// Poll register: one part, read again without relatching.
		c = n_com;
		w = $random(seed);
		reg_rdata <= w;
		part(POLL_ADDR, 1'b0, 1'b0, w);
		expq.push_back(w[15:0]);
		mhb_host_model_i.rd();
		`CHK(n_com - c, 2)
		// Strobe without chip select must not latch.
		mhb_host_model_i.latch(16'h0080, 1'b0, 1'b0);
		`CHK(latched_addr, POLL_ADDR)
		// Event during a lock waits for the last part.
		w = $random(seed);
		reg_rdata <= w;
		part(10'h030, 1'b0, 1'b0, w);
		`CHK(read_lock, 1'b1)
		hw_event <= 8'ha5;
		@(posedge clock);
		hw_event <= 8'h00;
		@(posedge clock);
		`CHK(ev_acc, 8'h00)
		part(10'h032, 1'b0, 1'b0, w);
		repeat (3) @(posedge clock);
		`CHK(ev_acc, 8'ha5)
		// Power drop in mid DWORD, then a read that straddles the return.
		w = $random(seed);
		reg_rdata <= w;
		part(10'h050, 1'b0, 1'b0, w);
		`CHK(rd_count, 2'h1)
		full_power_state <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(rd_count, COUNT_RST)
		`CHK(read_lock, 1'b0)
		fork
			mhb_host_model_i.rd();
			begin
				repeat (2) @(posedge clock);
				full_power_state <= 1'b1;
			end
		join
		`CHK(rd_count, COUNT_RST)
		dw(10'h050, 1'b0, 1'b0);
		// Mid-run reset into 8-bit, dual phase, enable with direction.
		rst <= 1'b1;
		wide_cfg <= 1'b0;
		dual_cfg <= 1'b1;
		style_cfg <= 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(latched_addr, ADDR_RST)
		// High strobe first, then low strobes only; big endian bytes.
		c = n_com;
		w = $random(seed);
		reg_rdata <= w;
		mhb_host_model_i.latch(16'h0005, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			if (i == 1) begin
				// Clock enable low: a whole read passes unseen.
				ce <= 1'b0;
				mhb_host_model_i.rd();
				ce <= 1'b1;
				`CHK(rd_count, 2'h1)
			end
			expq.push_back({8'h00, w[8 * (3 - i) +: 8]});
			mhb_host_model_i.latch(16'h0010 + 16'(i), 1'b1, 1'b0);
			mhb_host_model_i.rd();
			reg_rdata <= ~w;
		end
		`CHK(latched_addr, 10'h113)
		`CHK(latched_endian, 1'b1)
		`CHK(n_com - c, 1)
		`CHK(expq.size(), 0)
		conclude();
	end
endmodule

`default_nettype wire
